// File: hw/uli_change_det.sv
// Change detector: pulses when a sampled vector differs from its previous sample.
`include "uli_consts.svh"
`default_nettype none
module uli_change_det #(
  parameter int W = 6
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic sample_i,
  input wire logic [W-1:0] value_i,
  output logic change_o
);
  import uli_pkg::*;

  logic [W-1:0] prev_r;
  logic [W-1:0] prev_nxt;
  logic primed_r;
  logic primed_nxt;

  // The first sample after reset only primes, so reset values cause no false change.
  always_comb begin
    prev_nxt = sample_i ? value_i : prev_r;
    primed_nxt = primed_r | sample_i;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      prev_r <= '0;
      primed_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      primed_r <= primed_nxt;
    end
  end

  assign change_o = sample_i & primed_r & (value_i != prev_r);

  a_change_pulse_cause: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    change_o |=> (prev_r == $past(value_i)) && $past(value_i) != $past(prev_r))
    else $error("change pulse without a differing sample");
endmodule
`default_nettype wire

// File: hw/uli_top.sv
// Line event flags, enables, status readback and interrupt request.
//
// Behaviour
// - Each event flag is set to one by its event and all flags clear when the flag register is read.
// - The superframe flag, bit 7, is set at the start of every received superframe.
// - The half superframe flag, bit 6, is set just after each received channel message is processed.
// - The block error flag, bit 5, is set at a superframe boundary if the previous one saw an error.
// - The latest near-end and far-end block error indications stay readable in status register 0.
// - The activation change flag, bit 4, is set when any of the six activation status bits changes.
// - The other state change flag, bit 3, is set when any of the seven other status bits changes.
// - The verified message flag, bit 2, is set when a thrice-confirmed message differs from the last.
// - The raw message flag, bit 1, is set whenever a message differs from the one before it.
// - Bit 0 mirrors the corrupt CRC notify state, never interrupts and has no enable.
// - Enable bits 7 to 1 forward their flag as an interrupt when one and block it when zero.
//
// Chosen here: the address-and-strobe port.
`include "uli_consts.svh"
`default_nettype none
module uli_top (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire uli_pkg::uli_byte_t reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output uli_pkg::uli_byte_t reg_rdata_o,
  input wire logic superframe_start_i,
  input wire logic half_superframe_done_i,
  input wire uli_pkg::uli_msg_t eoc_msg_i,
  input wire logic near_end_block_error_i,
  input wire logic far_end_block_error_i,
  input wire logic [`ULI_ACT_W-1:0] activation_status_i,
  input wire logic [`ULI_OTHER_W-1:0] other_status_i,
  input wire logic corrupt_crc_notify_i,
  input wire logic automatic_channel_processing_mode_i,
  output logic irq_o
);
  import uli_pkg::*;

  // Address match used by the read, clear and enable strobe decodes; the read data mux uses its own case.
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
    hit = (addr == offset);
  endfunction

  uli_byte_t flags_r;
  uli_byte_t flags_nxt;
  uli_byte_t enables_r;
  uli_byte_t enables_nxt;
  uli_byte_t rdata_r;
  uli_byte_t rdata_nxt;
  logic irq_r;
  logic irq_nxt;
  logic near_acc_r;
  logic near_acc_nxt;
  logic far_acc_r;
  logic far_acc_nxt;
  logic near_last_r;
  logic near_last_nxt;
  logic far_last_r;
  logic far_last_nxt;

  uli_byte_t set_vec;
  uli_byte_t clr_vec;
  logic act_change;
  logic other_change;
  logic raw_new;
  logic verified_new;
  logic flags_read;
  logic clear_write;
  logic enables_write;

  // Activation status watcher, sampled every cycle.
  uli_change_det #(
    .W(`ULI_ACT_W)
  ) u_act_det (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .sample_i(1'b1),
    .value_i(activation_status_i),
    .change_o(act_change)
  );

  // Other line status watcher, sampled every cycle.
  uli_change_det #(
    .W(`ULI_OTHER_W)
  ) u_other_det (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .sample_i(1'b1),
    .value_i(other_status_i),
    .change_o(other_change)
  );

  // Raw message watcher, sampled once per processed message.
  uli_change_det #(
    .W(`ULI_MSG_W)
  ) u_raw_det (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .sample_i(half_superframe_done_i),
    .value_i(eoc_msg_i),
    .change_o(raw_new)
  );

  // Three-fold confirmation of processed messages.
  uli_verify u_verify (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .strobe_i(half_superframe_done_i),
    .msg_i(eoc_msg_i),
    .new_o(verified_new)
  );

  // Register port decode.
  always_comb begin
    flags_read = reg_rd_i & hit(reg_addr_i, `ULI_ADDR_FLAGS);
    clear_write = reg_wr_i & hit(reg_addr_i, `ULI_ADDR_CLEAR);
    enables_write = reg_wr_i & hit(reg_addr_i, `ULI_ADDR_ENABLES);
  end

  // Block error indications are gathered over a superframe and judged at its end.
  always_comb begin
    near_acc_nxt = near_acc_r | near_end_block_error_i;
    far_acc_nxt = far_acc_r | far_end_block_error_i;
    near_last_nxt = near_last_r;
    far_last_nxt = far_last_r;
    if (superframe_start_i) begin
      near_acc_nxt = near_end_block_error_i;
      far_acc_nxt = far_end_block_error_i;
      near_last_nxt = near_acc_r;
      far_last_nxt = far_acc_r;
    end
  end

  // Event sources collected into the flag layout.
  always_comb begin
    set_vec = `ULI_RESET_BYTE;
    set_vec[`ULI_BIT_SUPERFRAME] = superframe_start_i;
    set_vec[`ULI_BIT_HALF_SUPERFRAME] = half_superframe_done_i;
    set_vec[`ULI_BIT_BLOCK_ERROR] = superframe_start_i & (near_acc_r | far_acc_r);
    set_vec[`ULI_BIT_ACTIVATION] = act_change;
    set_vec[`ULI_BIT_OTHER_STATE] = other_change;
    set_vec[`ULI_BIT_VERIFIED_MSG] = verified_new;
    set_vec[`ULI_BIT_RAW_MSG] = raw_new;
  end

  // Sticky flags: a read or a clear write removes them, a new event in the same cycle wins.
  always_comb begin
    clr_vec = `ULI_RESET_BYTE;
    if (flags_read) begin
      clr_vec = `ULI_IRQ_MASK;
    end
    if (clear_write) begin
      clr_vec = clr_vec | reg_wdata_i;
    end
    flags_nxt = ((flags_r & ~clr_vec) | set_vec) & `ULI_IRQ_MASK;
  end

  // Enable register; bit 0 has no storage and reads as zero.
  always_comb begin
    enables_nxt = enables_r;
    if (enables_write) begin
      enables_nxt = reg_wdata_i & `ULI_IRQ_MASK;
    end
  end

  // Interrupt request follows the next flag and enable state so it lines up with them.
  always_comb begin
    irq_nxt = |(flags_nxt & enables_nxt & `ULI_IRQ_MASK);
  end

  // Read data mux; an unmapped address and the write-only clear register read zero.
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd_i) begin
      rdata_nxt = `ULI_RESET_BYTE;
      case (reg_addr_i)
        `ULI_ADDR_FLAGS: begin
          rdata_nxt = flags_r;
          rdata_nxt[`ULI_BIT_CRC_NOTIFY] = corrupt_crc_notify_i;
        end
        `ULI_ADDR_ENABLES: begin
          rdata_nxt = enables_r;
        end
        `ULI_ADDR_STATUS0: begin
          rdata_nxt[`ULI_ACT_W-1:0] = activation_status_i;
          rdata_nxt[`ULI_BIT_NEAR_END_ERR] = near_last_r;
          rdata_nxt[`ULI_BIT_FAR_END_ERR] = far_last_r;
        end
        `ULI_ADDR_STATUS1: begin
          rdata_nxt[`ULI_OTHER_W-1:0] = other_status_i;
          rdata_nxt[`ULI_BIT_AUTO_MODE] = automatic_channel_processing_mode_i;
        end
        default: begin
          rdata_nxt = `ULI_RESET_BYTE;
        end
      endcase
    end
  end

  // State registers, all zero after reset.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      flags_r <= `ULI_RESET_BYTE;
      enables_r <= `ULI_RESET_BYTE;
      rdata_r <= `ULI_RESET_BYTE;
      irq_r <= 1'b0;
      near_acc_r <= 1'b0;
      far_acc_r <= 1'b0;
      near_last_r <= 1'b0;
      far_last_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      enables_r <= enables_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
      near_acc_r <= near_acc_nxt;
      far_acc_r <= far_acc_nxt;
      near_last_r <= near_last_nxt;
      far_last_r <= far_last_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign irq_o = irq_r;

  // Checks on the flag, enable and interrupt behaviour.
  a_read_clears_flags: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (reg_rd_i && reg_addr_i == `ULI_ADDR_FLAGS && set_vec == 8'h00)
      |=> flags_r == 8'h00)
    else $error("flag read did not clear the flags");

  a_read_returns_flags: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (reg_rd_i && reg_addr_i == `ULI_ADDR_FLAGS)
      |=> reg_rdata_o[7:1] == $past(flags_r[7:1]))
    else $error("flag read returned the wrong value");

  a_superframe_flag_set: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    superframe_start_i |=> flags_r[`ULI_BIT_SUPERFRAME])
    else $error("superframe flag not set");

  a_half_flag_set: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    half_superframe_done_i |=> flags_r[`ULI_BIT_HALF_SUPERFRAME])
    else $error("half superframe flag not set");

  a_block_error_flag: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (superframe_start_i && (near_acc_r || far_acc_r))
      |=> flags_r[`ULI_BIT_BLOCK_ERROR] && near_last_r == $past(near_acc_r))
    else $error("block error not reported at the next boundary");

  a_clear_write_drops: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (reg_wr_i && reg_addr_i == `ULI_ADDR_CLEAR)
      |=> (flags_r & $past(reg_wdata_i & ~set_vec)) == 8'h00)
    else $error("clear write left a flag set");

  a_rdata_holds: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !$past(reg_rd_i) |-> $stable(reg_rdata_o))
    else $error("read data changed without a read");

  a_activation_change: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ($past(rst_n_i, 2) && $changed(activation_status_i))
      |=> flags_r[`ULI_BIT_ACTIVATION])
    else $error("activation change not flagged");

  a_other_change: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ($past(rst_n_i, 2) && $changed(other_status_i))
      |=> flags_r[`ULI_BIT_OTHER_STATE])
    else $error("other state change not flagged");

  a_crc_bit_mirror: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (reg_rd_i && reg_addr_i == `ULI_ADDR_FLAGS)
      |=> reg_rdata_o[0] == $past(corrupt_crc_notify_i) && !flags_r[0])
    else $error("notify bit does not mirror its input");

  a_irq_masked_off: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (reg_wr_i && reg_addr_i == `ULI_ADDR_ENABLES && reg_wdata_i == 8'h00)
      |=> !irq_o && enables_r == 8'h00)
    else $error("interrupt high with all enables cleared");

  a_irq_follows_flags: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) |-> irq_o == |(flags_r & enables_r))
    else $error("interrupt request disagrees with enabled flags");
endmodule
`default_nettype wire

// File: hw/uli_verify.sv
// Three-fold confirmation of channel messages with a pulse on a new verified message.
`include "uli_consts.svh"
`default_nettype none
module uli_verify (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic strobe_i,
  input wire uli_pkg::uli_msg_t msg_i,
  output logic new_o
);
  import uli_pkg::*;

  uli_ver_state_t state_r;
  uli_ver_state_t state_nxt;
  uli_msg_t cand_r;
  uli_msg_t cand_nxt;
  uli_msg_t conf_r;
  uli_msg_t conf_nxt;
  logic new_r;
  logic new_nxt;

  // A candidate is confirmed on its third equal arrival in a row.
  always_comb begin
    state_nxt = state_r;
    cand_nxt = cand_r;
    conf_nxt = conf_r;
    new_nxt = 1'b0;
    if (strobe_i) begin
      if (state_r == VER_EMPTY || msg_i != cand_r) begin
        state_nxt = VER_ONE;
        cand_nxt = msg_i;
      end else begin
        case (state_r)
          VER_ONE: begin
            state_nxt = VER_TWO;
          end
          VER_TWO: begin
            state_nxt = VER_LOCKED;
            conf_nxt = msg_i;
            new_nxt = (msg_i != conf_r);
          end
          default: begin
            state_nxt = state_r;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_r <= VER_EMPTY;
      cand_r <= '0;
      conf_r <= '0;
      new_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cand_r <= cand_nxt;
      conf_r <= conf_nxt;
      new_r <= new_nxt;
    end
  end

  assign new_o = new_r;

  a_verify_needs_three: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    new_r |-> state_r == VER_LOCKED && $past(state_r) == VER_TWO)
    else $error("verified pulse without a third equal message");
endmodule
`default_nettype wire

// File: shared/uli_consts.svh
// Offsets, field positions, reset values and widths of the line event flag block.
`ifndef ULI_CONSTS_SVH
`define ULI_CONSTS_SVH

// Register offsets on the plain register port.
`define ULI_ADDR_FLAGS 8'h14
`define ULI_ADDR_ENABLES 8'h15
`define ULI_ADDR_CLEAR 8'h18
`define ULI_ADDR_STATUS0 8'h19
`define ULI_ADDR_STATUS1 8'h1A

// Bit positions inside the event flag and enable registers.
`define ULI_BIT_SUPERFRAME 7
`define ULI_BIT_HALF_SUPERFRAME 6
`define ULI_BIT_BLOCK_ERROR 5
`define ULI_BIT_ACTIVATION 4
`define ULI_BIT_OTHER_STATE 3
`define ULI_BIT_VERIFIED_MSG 2
`define ULI_BIT_RAW_MSG 1
`define ULI_BIT_CRC_NOTIFY 0

// Bit positions inside the first and second line status registers.
`define ULI_BIT_NEAR_END_ERR 7
`define ULI_BIT_FAR_END_ERR 6
`define ULI_BIT_AUTO_MODE 7

// Reset values and masks.
`define ULI_RESET_BYTE 8'h00
`define ULI_IRQ_MASK 8'hFE

// Widths of the status groups and of one channel message.
`define ULI_ACT_W 6
`define ULI_OTHER_W 7
`define ULI_MSG_W 12

// Equal messages in a row needed before a message counts as verified.
`define ULI_CONFIRM_COUNT 3

`endif

// File: shared/uli_pkg.sv
// Types shared by the line event flag block.
`include "uli_consts.svh"
`default_nettype none
package uli_pkg;
  typedef logic [7:0] uli_byte_t;
  typedef logic [`ULI_MSG_W-1:0] uli_msg_t;
  typedef enum logic [1:0] {VER_EMPTY, VER_ONE, VER_TWO, VER_LOCKED} uli_ver_state_t;
endpackage
`default_nettype wire

// File: verif/tb.sv
// Bench of the line event flag block: a table of event rows, then hand tests.
`include "uli_consts.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import uli_pkg::*;
  typedef struct {logic sf, hsf, ne, fe; uli_msg_t msg; logic [5:0] act; logic [6:0] oth;
    uli_byte_t flg, st0;} uli_row_t;
  logic ref_clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic sf = 1'h0;
  logic hsf = 1'h0;
  logic ne = 1'h0;
  logic fe = 1'h0;
  logic crc = 1'h0;
  logic auto_m = 1'h0;
  logic wr, rd, irq;
  logic [7:0] addr;
  uli_byte_t wdata, rdata, d;
  uli_msg_t msg = '0;
  logic [5:0] act = '0;
  logic [6:0] oth = '0;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  uli_row_t rows [14];

  // The clock toggles every half period of 2 ns.
  always #2 ref_clk_i = ~ref_clk_i;

  uli_top u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .superframe_start_i(sf), .half_superframe_done_i(hsf), .eoc_msg_i(msg),
    .near_end_block_error_i(ne), .far_end_block_error_i(fe), .activation_status_i(act),
    .other_status_i(oth), .corrupt_crc_notify_i(crc),
    .automatic_channel_processing_mode_i(auto_m), .irq_o(irq));
  uli_host_model u_host (.ref_clk_i(ref_clk_i), .reg_addr_o(addr), .reg_wdata_o(wdata),
    .reg_wr_o(wr), .reg_rd_o(rd), .reg_rdata_i(rdata));

  // Compares one value and counts it.
  task automatic chk(input string nm, input uli_byte_t seen, input uli_byte_t exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Reads a register through the host model and compares it.
  task automatic rdchk(input string nm, input logic [7:0] a, input uli_byte_t exp);
    u_host.rd(a, d);
    chk(nm, d, exp);
  endtask

  // Applies one row of events, then checks the request line and the registers.
  task automatic run_row(input uli_row_t r);
    @(posedge ref_clk_i);
    {sf, hsf, ne, fe} <= {r.sf, r.hsf, r.ne, r.fe};
    {msg, act, oth} <= {r.msg, r.act, r.oth};
    @(posedge ref_clk_i);
    {sf, hsf, ne, fe} <= 4'h0;
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk("irq", {7'h0, irq}, {7'h0, |(r.flg & `ULI_IRQ_MASK)});
    rdchk("flags", `ULI_ADDR_FLAGS, r.flg);
    rdchk("status0", `ULI_ADDR_STATUS0, r.st0);
    rdchk("status1", `ULI_ADDR_STATUS1, {1'h0, r.oth});
    chk("irq after read", {7'h0, irq}, 8'h00);
  endtask

  // A hang is cut short well after the expected length of the run.
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      print_verdict();
    end
  end

  // Main sequence: reset, the table of rows, then the awkward cases.
  initial begin
    rows = '{
      '{1, 0, 0, 0, 12'h000, 6'h00, 7'h00, 8'h80, 8'h00},
      '{0, 1, 0, 0, 12'h123, 6'h00, 7'h00, 8'h40, 8'h00},
      '{0, 1, 0, 0, 12'h123, 6'h00, 7'h00, 8'h40, 8'h00},
      '{0, 1, 0, 0, 12'h123, 6'h00, 7'h00, 8'h44, 8'h00},
      '{0, 1, 0, 0, 12'h456, 6'h00, 7'h00, 8'h42, 8'h00},
      '{0, 0, 1, 0, 12'h456, 6'h00, 7'h00, 8'h00, 8'h00},
      '{1, 0, 0, 0, 12'h456, 6'h00, 7'h00, 8'hA0, 8'h80},
      '{1, 0, 0, 0, 12'h456, 6'h00, 7'h00, 8'h80, 8'h00},
      '{1, 0, 0, 1, 12'h456, 6'h00, 7'h00, 8'h80, 8'h00},
      '{1, 0, 0, 0, 12'h456, 6'h00, 7'h00, 8'hA0, 8'h40},
      '{0, 0, 0, 0, 12'h456, 6'h01, 7'h00, 8'h10, 8'h41},
      '{0, 0, 0, 0, 12'h456, 6'h20, 7'h00, 8'h10, 8'h60},
      '{0, 0, 0, 0, 12'h456, 6'h20, 7'h40, 8'h08, 8'h60},
      '{0, 0, 0, 0, 12'h456, 6'h20, 7'h01, 8'h08, 8'h60}};
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'h1;
    rdchk("flags reset", `ULI_ADDR_FLAGS, `ULI_RESET_BYTE);
    rdchk("enables reset", `ULI_ADDR_ENABLES, `ULI_RESET_BYTE);
    u_host.wr(`ULI_ADDR_ENABLES, 8'hFF);
    rdchk("enables bit0", `ULI_ADDR_ENABLES, `ULI_IRQ_MASK);
    $display("reset test done");
    foreach (rows[i]) begin
      run_row(rows[i]);
      $display("row %0d done", i);
    end
    // Only the superframe flag may raise the request; the clear register drops it.
    u_host.wr(`ULI_ADDR_ENABLES, 8'h80);
    oth <= 7'h00;
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk("irq masked", {7'h0, irq}, 8'h00);
    @(posedge ref_clk_i);
    sf <= 1'h1;
    @(posedge ref_clk_i);
    sf <= 1'h0;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("irq enabled", {7'h0, irq}, 8'h01);
    u_host.wr(`ULI_ADDR_CLEAR, 8'h80);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("irq cleared", {7'h0, irq}, 8'h00);
    rdchk("flags left", `ULI_ADDR_FLAGS, 8'h08);
    $display("mask and clear test done");
    // Bit 0 mirrors the notify input and never raises the request; status 1 shows the mode.
    @(posedge ref_clk_i);
    crc <= 1'h1;
    auto_m <= 1'h1;
    u_host.wr(`ULI_ADDR_ENABLES, 8'hFF);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("irq notify", {7'h0, irq}, 8'h00);
    rdchk("status1 auto", `ULI_ADDR_STATUS1, 8'h80);
    rdchk("notify set", `ULI_ADDR_FLAGS, 8'h01);
    @(posedge ref_clk_i);
    crc <= 1'h0;
    rdchk("notify gone", `ULI_ADDR_FLAGS, 8'h00);
    $display("notify test done");
    // An event in the cycle of the read survives the clear.
    fork
      rdchk("read with event", `ULI_ADDR_FLAGS, 8'h00);
      begin
        @(posedge ref_clk_i);
        sf <= 1'h1;
        @(posedge ref_clk_i);
        sf <= 1'h0;
      end
    join
    rdchk("event kept", `ULI_ADDR_FLAGS, 8'h80);
    u_host.wr(`ULI_ADDR_FLAGS, 8'hFF);
    u_host.wr(8'h20, 8'hFF);
    rdchk("flags read only", `ULI_ADDR_FLAGS, 8'h00);
    rdchk("unmapped", 8'h20, 8'h00);
    rdchk("clear reads zero", `ULI_ADDR_CLEAR, 8'h00);
    $display("collision and map test done");
    // A second reset in mid-run wipes the enables.
    @(posedge ref_clk_i);
    rst_n_i <= 1'h0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'h1;
    rdchk("enables rereset", `ULI_ADDR_ENABLES, `ULI_RESET_BYTE);
    $display("second reset test done");
    print_verdict();
  end
endmodule
`default_nettype wire

// File: verif/uli_host_model.sv
// Register port master that stands in for the on-chip microcontroller.
`include "uli_consts.svh"
`default_nettype none
module uli_host_model (
  input wire logic ref_clk_i,
  output logic [7:0] reg_addr_o,
  output uli_pkg::uli_byte_t reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire uli_pkg::uli_byte_t reg_rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  import uli_pkg::*;

  // The bus idles with both strobes low from time zero.
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'h0;
    reg_rd_o = 1'h0;
  end

  // One-cycle write; the strobe drops again at the following clock edge and no reply is awaited.
  task automatic wr(input logic [7:0] a, input uli_byte_t v);
    @(posedge ref_clk_i);
    reg_wr_o <= 1'h1;
    reg_addr_o <= a;
    reg_wdata_o <= v;
    @(posedge ref_clk_i);
    reg_wr_o <= 1'h0;
  endtask

  // One-cycle read; the data are taken in the cycle after the strobe only.
  task automatic rd(input logic [7:0] a, output uli_byte_t v);
    @(posedge ref_clk_i);
    reg_rd_o <= 1'h1;
    reg_addr_o <= a;
    @(posedge ref_clk_i);
    reg_rd_o <= 1'h0;
    #1;
    v = reg_rdata_i;
  endtask
endmodule
`default_nettype wire
